// ==== rtl/shift_register_pkg.sv ====
// constants shared by the eight-stage serial shift register
// Overview of operation
// - eight-bit register, serial entry at first stage, serial exit at last stage only.
// - eight storage stages share one internal clock line and advance together.
// - two serial inputs gated and inverted into complementary set/reset drive of stage one.
// - each rising shift clock edge moves bits toward output and loads stage one.
// - serial output equals the gated input sampled eight shift edges earlier.
package shift_register_pkg;
  localparam int STAGE_COUNT = 8;
  localparam int SHIFT_LATENCY = 8;
  localparam logic STAGE_RESET = 1'h0;
  localparam logic [3:0] FILL_RESET = 4'h0;
  localparam logic [3:0] FILL_FULL = 4'h8;
  localparam logic [STAGE_COUNT-1:0] HISTORY_RESET = 8'h00;
endpackage

// ==== rtl/shift_stage.sv ====
// one set/reset storage stage of the shift chain
`timescale 1ns/100ps
module shift_stage
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic advance,
  input wire logic setDrive,
  input wire logic resetDrive,
  output logic q
);
  import shift_register_pkg::*;

  logic next_q;

  // holds when neither or both drives are active
  assign next_q = (setDrive & ~resetDrive) ? 1'h1 :
                  (resetDrive & ~setDrive) ? 1'h0 : q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= STAGE_RESET;
    end else if (advance) begin
      q <= next_q;
    end
  end
endmodule

// ==== rtl/serial_shift_register_8bit.sv ====
// eight-stage serial-in serial-out shift register
`timescale 1ns/100ps
module serial_shift_register_8bit
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic shift_clock,
  input wire logic serialInA,
  input wire logic serialInB,
  output logic serialOut
);
  import shift_register_pkg::*;

  logic shiftClockPrev;
  logic clockLine;
  logic advance;
  logic gatedIn;
  logic gatedInN;
  logic [STAGE_COUNT-1:0] setDrive;
  logic [STAGE_COUNT-1:0] resetDrive;
  logic [STAGE_COUNT-1:0] stageQ;

  assign gatedIn = serialInA & serialInB;
  assign gatedInN = ~gatedIn;
  // inverting driver onto the common line; a falling line is a rising pin edge
  assign clockLine = ~shift_clock;
  assign advance = ~clockLine & ~shiftClockPrev;

  // pin must hold each level at least one ref_clk cycle or edges are missed
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shiftClockPrev <= 1'h1;
    end else begin
      shiftClockPrev <= shift_clock;
    end
  end

  assign setDrive = {stageQ[STAGE_COUNT-2:0], gatedIn};
  assign resetDrive = {~stageQ[STAGE_COUNT-2:0], gatedInN};

  genvar i;
  generate
    for (i = 0; i < STAGE_COUNT; i++) begin : g_stage
      shift_stage u_stage (
        .ref_clk(ref_clk),
        .reset(reset),
        .advance(advance),
        .setDrive(setDrive[i]),
        .resetDrive(resetDrive[i]),
        .q(stageQ[i])
      );

      AST_STAGE_STEP: assert property (
        @(posedge ref_clk) disable iff (reset)
        advance |=> stageQ[i] == $past(setDrive[i]))
        else $error("stage did not take its drive on a shift edge");

      AST_STAGE_HOLD: assert property (
        @(posedge ref_clk) disable iff (reset)
        !advance |=> $stable(stageQ[i]))
        else $error("stage changed between shift edges");
    end
  endgenerate

  assign serialOut = stageQ[STAGE_COUNT-1];

  // eight-edge history
  // independent copy of the gated input, read only by the checks
  logic [STAGE_COUNT-1:0] history;
  logic [3:0] fillCount;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      history <= HISTORY_RESET;
      fillCount <= FILL_RESET;
    end else if (advance) begin
      history <= {history[STAGE_COUNT-2:0], gatedIn};
      if (fillCount != FILL_FULL) begin
        fillCount <= fillCount + 4'h1;
      end
    end
  end

  AST_OUT_LAST: assert property (
    @(posedge ref_clk) disable iff (reset)
    $changed(serialOut) |-> $past(advance) && serialOut == $past(stageQ[STAGE_COUNT-2]))
    else $error("serial output not taken from last stage");

  AST_OUT_STANDS: assert property (
    @(posedge ref_clk) disable iff (reset)
    !advance |=> $stable(serialOut))
    else $error("serial output moved without a shift edge");

  AST_OUT_ZERO_FILL: assert property (
    @(posedge ref_clk) disable iff (reset)
    fillCount != FILL_FULL |-> !serialOut)
    else $error("serial output set before eight shifts since reset");

  AST_RESET_CLEAR: assert property (
    @(posedge ref_clk)
    reset |=> stageQ == {STAGE_COUNT{STAGE_RESET}} && history == HISTORY_RESET &&
      fillCount == FILL_RESET)
    else $error("reset did not clear the stages");

  AST_RESET_PREV: assert property (
    @(posedge ref_clk)
    reset |=> shiftClockPrev)
    else $error("reset did not park the edge detector high");

  AST_HOLD_TOGETHER: assert property (
    @(posedge ref_clk) disable iff (reset)
    !advance |=> $stable(stageQ))
    else $error("stages moved without a shift edge");

  AST_EDGE_ONLY: assert property (
    @(posedge ref_clk) disable iff (reset)
    advance |-> $rose(shift_clock))
    else $error("advance without rising shift clock");

  AST_LINE_FALLS: assert property (
    @(posedge ref_clk) disable iff (reset)
    advance |-> $fell(clockLine))
    else $error("advance without a falling common clock line");

  AST_EDGE_SEEN: assert property (
    @(posedge ref_clk) disable iff (reset)
    $rose(shift_clock) && !$past(reset) |-> advance)
    else $error("rising shift clock did not advance the stages");

  AST_PREV_TRACKS: assert property (
    @(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> shiftClockPrev == $past(shift_clock))
    else $error("edge detector lost the shift clock level");

  AST_NO_SHIFT_AT_RELEASE: assert property (
    @(posedge ref_clk)
    $fell(reset) |-> !advance)
    else $error("shift taken at the edge of reset release");

  AST_SPACING: assert property (
    @(posedge ref_clk) disable iff (reset)
    advance |=> !advance)
    else $error("two advances on consecutive cycles");

  AST_COMPLEMENT: assert property (
    @(posedge ref_clk) disable iff (reset)
    setDrive[0] == (serialInA && serialInB) && setDrive[0] != resetDrive[0])
    else $error("first stage drives not complementary");

  AST_SHIFT: assert property (
    @(posedge ref_clk) disable iff (reset)
    advance |=> stageQ[STAGE_COUNT-1:1] == $past(stageQ[STAGE_COUNT-2:0]))
    else $error("bits did not move one stage");

  AST_LOAD: assert property (
    @(posedge ref_clk) disable iff (reset)
    advance |=> stageQ[0] == $past(gatedIn))
    else $error("first stage not loaded from gated input");

  AST_LATENCY: assert property (
    @(posedge ref_clk) disable iff (reset)
    fillCount == FILL_FULL |-> serialOut == history[SHIFT_LATENCY-1])
    else $error("output differs from input eight edges earlier");

  AST_HISTORY_MATCH: assert property (
    @(posedge ref_clk) disable iff (reset)
    history == stageQ)
    else $error("stages differ from the gated input history");

  AST_FILL_STEP: assert property (
    @(posedge ref_clk) disable iff (reset)
    advance && fillCount != FILL_FULL |=> fillCount == $past(fillCount) + 4'h1)
    else $error("fill count missed a shift edge");

  AST_FILL_HOLD: assert property (
    @(posedge ref_clk) disable iff (reset)
    !advance |=> $stable(fillCount))
    else $error("fill count moved without a shift edge");

  AST_FILL_LIMIT: assert property (
    @(posedge ref_clk) disable iff (reset)
    fillCount <= FILL_FULL)
    else $error("fill count above the stage count");

  AST_FULL_STAYS: assert property (
    @(posedge ref_clk) disable iff (reset)
    fillCount == FILL_FULL |=> fillCount == FILL_FULL)
    else $error("fill count left full without reset");

  AST_AND_GATE: assert property (
    @(posedge ref_clk) disable iff (reset)
    advance && !(serialInA && serialInB) |=> !stageQ[0])
    else $error("first stage loaded one while an input was low");

  AST_GATE_ONE: assert property (
    @(posedge ref_clk) disable iff (reset)
    advance && serialInA && serialInB |=> stageQ[0])
    else $error("first stage loaded zero while both inputs were high");
endmodule

// ==== verif/upstream_source.sv ====
// upstream source of serial data and shift clock
`timescale 1ns/100ps
module upstream_source (
  input wire logic ref_clk,
  output logic shift_clock,
  output logic serialInA,
  output logic serialInB
);
  initial begin
    shift_clock = 1'h0;
    serialInA = 1'h1;
    serialInB = 1'h1;
  end
  // caller holds spare input at 1; scramble only when both carry data
  task automatic send(input logic a, input logic b, input logic scramble);
    @(posedge ref_clk) #5;
    {serialInA, serialInB, shift_clock} = {a, b, 1'h1};
    // high one cycle; low-phase data must be ignored
    @(posedge ref_clk) #5;
    {serialInA, serialInB, shift_clock} = {a ^ scramble, b ^ scramble, 1'h0};
  endtask
  // parks the clock high, used across a reset release
  task automatic raise(input logic a, input logic b);
    @(posedge ref_clk) #5;
    {serialInA, serialInB, shift_clock} = {a, b, 1'h1};
  endtask
  task automatic lower();
    @(posedge ref_clk) #5;
    shift_clock = 1'h0;
  endtask
endmodule

// ==== verif/tb_serial_shift_register_8bit.sv ====
// self-checking bench for the eight-stage shift register
`timescale 1ns/100ps
module tb_serial_shift_register_8bit;
  logic ref_clk, reset, shift_clock, serialInA, serialInB, serialOut;
  logic [7:0] expected;
  int n_errors, comparisons;
  upstream_source upstream_source_i (.ref_clk(ref_clk), .shift_clock(shift_clock),
    .serialInA(serialInA), .serialInB(serialInB));
  serial_shift_register_8bit serial_shift_register_8bit_i (.ref_clk(ref_clk),
    .reset(reset), .shift_clock(shift_clock), .serialInA(serialInA),
    .serialInB(serialInB), .serialOut(serialOut));
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(input logic exp, input string what);
    comparisons++;
    if (serialOut !== exp) begin
      n_errors++;
      $display("FAIL %s expected %b seen %b", what, exp, serialOut);
    end
  endtask
  // one bit in; out comes the bit of eight shifts back
  task automatic shift_and_check(input logic a, input logic b, input logic scramble);
    upstream_source_i.send(a, b, scramble);
    expected = {expected[6:0], a & b};
    check(expected[7], "serialOut");
  endtask
  task automatic test_power_on();
    check(1'h0, "serialOut after reset");
    $display("test_power_on done");
  endtask
  task automatic test_walk();
    logic [7:0] walkA = 8'hB5;
    logic [7:0] walkB = 8'h4A;
    for (int i = 7; i >= 0; i--) begin
      shift_and_check(walkA[i], 1'h1, 1'h0);
    end
    for (int i = 7; i >= 0; i--) begin
      shift_and_check(1'h1, walkB[i], 1'h0);
    end
    $display("test_walk done");
  endtask
  task automatic test_gating();
    for (int i = 0; i < 12; i++) begin
      shift_and_check(i[0], i[1], 1'h1);
    end
    for (int i = 0; i < 8; i++) begin
      shift_and_check(1'h1, 1'h1, 1'h1);
    end
    $display("test_gating done");
  endtask
  // clock held high across release must not count as an edge
  task automatic test_mid_reset();
    for (int i = 0; i < 8; i++) begin
      shift_and_check(1'h1, 1'h1, 1'h0);
    end
    @(posedge ref_clk) #5;
    reset = 1'h1;
    upstream_source_i.raise(1'h1, 1'h1);
    repeat (2) @(posedge ref_clk);
    #5;
    reset = 1'h0;
    expected = 8'h00;
    repeat (2) @(posedge ref_clk);
    #5;
    check(1'h0, "serialOut after mid-run reset");
    upstream_source_i.lower();
    for (int i = 0; i < 8; i++) begin
      shift_and_check(1'h1, 1'h1, 1'h0);
    end
    $display("test_mid_reset done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    n_errors = 0;
    comparisons = 0;
    expected = 8'h00;
    reset = 1'h1;
    repeat (16) @(posedge ref_clk);
    #5 reset = 1'h0;
    test_power_on();
    test_walk();
    test_gating();
    test_mid_reset();
    report_and_stop();
  end
  // tests need about 130 cycles
  initial begin
    repeat (600) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end
endmodule
